// File: dv/ast_rx_model.sv
// behavioural receiver on the serial line: samples mid-bit, lsb first.
// assumes the bench gives the bit length in reference clocks.
`timescale 1ns/1ps

module ast_rx_model (
  input wire ref_clk_in, // reference clock
  input wire line_in, // resolved serial line
  input wire nine_in, // expect a ninth data bit
  input wire [15:0] bit_len_in // clocks per bit
);
  logic [8:0] rx_q[$];
  logic [8:0] sh;
  int n_frame_err = 0;

  initial begin
    forever begin
      @(negedge line_in);
      repeat (bit_len_in / 2) @(posedge ref_clk_in);
      sh = 9'h000;
      for (int i = 0; i < (nine_in ? 9 : 8); i++) begin
        repeat (bit_len_in) @(posedge ref_clk_in);
        sh[i] = line_in;
      end
      repeat (bit_len_in) @(posedge ref_clk_in);
      if (line_in !== 1'b1) n_frame_err++;
      rx_q.push_back(sh);
    end
  end
endmodule

// File: dv/ast_tx_assertions.sv
// port assertions for the serial transmitter, bound into ast_tx.
// assumes one clock domain and rate changes only between frames.
`timescale 1ns/1ps
`include "ast_regs.vh"

module ast_tx_assertions #(
  parameter DIV_W = 8
) (
  input wire ref_clk_in, // clock
  input wire rstn_in, // reset, active low
  input wire psel_in, // apb select
  input wire penable_in, // apb access
  input wire pwrite_in, // apb write
  input wire [7:0] paddr_in, // apb address
  input wire [31:0] pwdata_in, // apb write data
  input wire pslverr_out, // apb error
  input wire sleep_in, // asleep
  input wire transmit_pin_out, // line level
  input wire transmit_pin_oe_out, // line driven
  input wire buffer_empty_flag_out // buffer empty
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);

  wire acc_wr = psel_in & penable_in & pwrite_in;
  reg tx_en_ff;
  reg hs_ff;
  reg seen_ff;
  reg [DIV_W-1:0] div_ff;
  reg [15:0] zcnt_ff;
  wire [15:0] period = ({{(16-DIV_W){1'b0}}, div_ff} + 16'h1) * (hs_ff ? 16'h10 : 16'h40);

  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_en_ff <= 1'b0;
      hs_ff <= 1'b0;
      seen_ff <= 1'b0;
      div_ff <= {DIV_W{1'b0}};
      zcnt_ff <= 16'h0;
    end else begin
      if (acc_wr && paddr_in == `AST_OFF_CTRL) begin
        tx_en_ff <= pwdata_in[`AST_CTRL_TX_EN];
        hs_ff <= pwdata_in[`AST_CTRL_HIGH_SPEED];
      end
      if (acc_wr && paddr_in == `AST_OFF_DIV) begin
        div_ff <= pwdata_in[DIV_W-1:0];
      end
      if (acc_wr && paddr_in == `AST_OFF_HOLD) begin
        seen_ff <= 1'b1;
      end
      // frozen cycles in sleep do not lengthen the count
      if (transmit_pin_out) begin
        zcnt_ff <= 16'h0;
      end else if (!sleep_in) begin
        zcnt_ff <= zcnt_ff + 16'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_ctrl_wr;
    acc_wr && paddr_in == `AST_OFF_CTRL && !sleep_in;
  endsequence
  sequence s_hold_wr;
    acc_wr && paddr_in == `AST_OFF_HOLD && !sleep_in;
  endsequence

  a_hold_clears_flag: assert property (
    s_hold_wr |=> !buffer_empty_flag_out) else $error("flag not cleared");
  a_flag_sticky: assert property (
    buffer_empty_flag_out && !(acc_wr && paddr_in == `AST_OFF_HOLD)
    |=> buffer_empty_flag_out) else $error("flag fell");
  a_enable_sets_flag: assert property (
    s_ctrl_wr ##0 (pwdata_in[`AST_CTRL_TX_EN] && !tx_en_ff)
    |-> ##2 buffer_empty_flag_out) else $error("flag not set");
  a_disable_hiz: assert property (
    s_ctrl_wr ##0 !pwdata_in[`AST_CTRL_TX_EN] |=> !transmit_pin_oe_out) else $error("no hiz");
  a_enable_mark: assert property (
    $rose(transmit_pin_oe_out) |-> transmit_pin_out) else $error("not idle high");
  a_start_needs_data: assert property (
    $fell(transmit_pin_out) && transmit_pin_oe_out |-> seen_ff) else $error("early start");
  a_bit_period: assert property (
    $rose(transmit_pin_out) && transmit_pin_oe_out && $past(transmit_pin_oe_out)
    |-> zcnt_ff != 16'h0 && zcnt_ff % period == 16'h0) else $error("bit length");
  a_zero_run_max: assert property (
    transmit_pin_oe_out |-> {16'h0, zcnt_ff} <= {16'h0, period} * 32'ha)
    else $error("low run too long");
  a_sleep_freeze: assert property (
    sleep_in |=> $stable(transmit_pin_out)) else $error("moved in sleep");
endmodule

bind ast_tx ast_tx_assertions #(.DIV_W(DIV_W)) u_chk (
  .ref_clk_in, .rstn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
  .pslverr_out, .sleep_in, .transmit_pin_out, .transmit_pin_oe_out, .buffer_empty_flag_out
);

// File: dv/ast_tx_test.sv
// self-checking bench for ast_tx: apb tasks, receiver model on the line.
// assumes hdl/ on the include path; released line is pulled up.
`timescale 1ns/1ps
`include "ast_regs.vh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
$display("BAD t=%0t got=%h exp=%h", $time, a, e); end end

module ast_tx_test;
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, sleep_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, rdq;
  logic errq, nine = 1'b0;
  logic [15:0] bit_len = 16'h10;
  wire pready_out, pslverr_out, transmit_pin_out, transmit_pin_oe_out, buffer_empty_flag_out;
  wire [31:0] prdata_out;
  wire serial_line = transmit_pin_oe_out ? transmit_pin_out : 1'b1;
  int n_mismatch = 0, cmp_count = 0;

  ast_tx u_dut (.ref_clk_in, .rstn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .pready_out, .pslverr_out, .prdata_out, .sleep_in, .transmit_pin_out,
    .transmit_pin_oe_out, .buffer_empty_flag_out);
  ast_rx_model u_rx (.ref_clk_in, .line_in(serial_line), .nine_in(nine), .bit_len_in(bit_len));

  always #5 ref_clk_in = ~ref_clk_in;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge ref_clk_in);
    penable_in <= 1'b1;
    do @(posedge ref_clk_in); while (pready_out !== 1'b1);
    rdq = prdata_out;
    errq = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic rx(input logic [8:0] e);
    int k;
    logic [8:0] v;
    k = 0;
    while (u_rx.rx_q.size() == 0 && k < 20000) begin
      @(posedge ref_clk_in);
      k++;
    end
    v = (u_rx.rx_q.size() != 0) ? u_rx.rx_q.pop_front() : ~e;
    `CHK(v, e)
    repeat (16) @(posedge ref_clk_in);
  endtask

  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    #1;
    `CHK({buffer_empty_flag_out, transmit_pin_oe_out}, 2'b00)
    apb(1'b0, `AST_OFF_CTRL, 32'h0);
    `CHK(rdq, 32'h2)
    apb(1'b0, 8'h1c, 32'h0);
    `CHK({errq, rdq}, 33'h1_0000_0000)
    apb(1'b1, `AST_OFF_DIV, 32'h0);
    apb(1'b1, `AST_OFF_PORT, 32'h80);
    apb(1'b1, `AST_OFF_CTRL, 32'h24);
    @(posedge ref_clk_in);
    #1;
    `CHK({buffer_empty_flag_out, transmit_pin_oe_out, transmit_pin_out}, 3'b111)
    apb(1'b1, `AST_OFF_FLAGS, 32'h0);
    #1;
    `CHK(buffer_empty_flag_out, 1'b1)
    apb(1'b1, `AST_OFF_CTRL, 32'h34);
    #1;
    `CHK(transmit_pin_oe_out, 1'b0)
    apb(1'b1, `AST_OFF_CTRL, 32'h24);
  endtask

  task automatic t_b2b;
    apb(1'b1, `AST_OFF_HOLD, 32'ha5);
    #1;
    `CHK(buffer_empty_flag_out, 1'b0)
    @(posedge ref_clk_in);
    #1;
    `CHK(buffer_empty_flag_out, 1'b1)
    apb(1'b1, `AST_OFF_HOLD, 32'h3c);
    apb(1'b0, `AST_OFF_CTRL, 32'h0);
    `CHK({rdq[1], buffer_empty_flag_out}, 2'b00)
    rx(9'h0a5);
    `CHK(buffer_empty_flag_out, 1'b1)
    rx(9'h03c);
  endtask

  task automatic t_nine;
    nine = 1'b1;
    for (int b = 0; b < 2; b++) begin
      apb(1'b1, `AST_OFF_CTRL, 32'h64 | b);
      apb(1'b1, `AST_OFF_HOLD, 32'h5a);
      rx({b[0], 8'h5a});
    end
    nine = 1'b0;
    apb(1'b1, `AST_OFF_CTRL, 32'h24);
  endtask

  task automatic t_abort;
    apb(1'b1, `AST_OFF_HOLD, 32'h00);
    repeat (40) @(posedge ref_clk_in);
    apb(1'b1, `AST_OFF_CTRL, 32'h04);
    #1;
    `CHK(transmit_pin_oe_out, 1'b0)
    repeat (200) @(posedge ref_clk_in);
    u_rx.rx_q.delete();
    apb(1'b1, `AST_OFF_HOLD, 32'h81);
    apb(1'b1, `AST_OFF_CTRL, 32'h24);
    rx(9'h081);
  endtask

  task automatic t_sleep;
    apb(1'b1, `AST_OFF_HOLD, 32'hc3);
    sleep_in <= 1'b1;
    repeat (100) @(posedge ref_clk_in);
    #1;
    `CHK({transmit_pin_out, buffer_empty_flag_out}, 2'b10)
    @(posedge ref_clk_in);
    sleep_in <= 1'b0;
    rx(9'h0c3);
  endtask

  task automatic t_slow;
    int k;
    k = 0;
    apb(1'b1, `AST_OFF_DIV, 32'h01);
    apb(1'b1, `AST_OFF_CTRL, 32'h20);
    bit_len = 16'h80;
    apb(1'b1, `AST_OFF_HOLD, 32'h97);
    @(negedge transmit_pin_out);
    while (transmit_pin_out === 1'b0 && k < 1000) begin
      @(posedge ref_clk_in);
      #1;
      k++;
    end
    `CHK(k, 128)
    rx(9'h097);
  endtask

  initial begin
    repeat (3) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    t_reset;
    t_b2b;
    t_nine;
    t_abort;
    t_sleep;
    t_slow;
    `CHK(u_rx.n_frame_err, 0)
    stop_test;
  end

  // whole run is near 3000 cycles
  initial begin
    #300000;
    n_mismatch++;
    stop_test;
  end
endmodule

// File: hdl/ast_baud.v
// baud divider: counts the reference clock down by (value + 1), then
// by 16 or 64, and gives one pulse per serial bit.
// assumes the run input is a level from the register domain.
`timescale 1ns/1ps
`include "ast_regs.vh"

module ast_baud #(
  parameter DIV_W = 8
) (
  input wire ref_clk_in, // system oscillator
  input wire rstn_in, // async reset, active low
  input wire run_in, // divider counting
  input wire high_speed_in, // 1: x16, 0: x64
  input wire [DIV_W-1:0] div_value_in, // baud_divider_value
  output wire bit_tick_out // one pulse per bit time
);

  reg [DIV_W-1:0] div_cnt_ff;
  reg [5:0] pre_cnt_ff;
  reg [DIV_W-1:0] nxt_div_cnt;
  reg [5:0] nxt_pre_cnt;
  wire div_tick;
  wire pre_end;

  assign div_tick = run_in && (div_cnt_ff == {DIV_W{1'b0}});
  assign pre_end = (pre_cnt_ff == (high_speed_in ? `AST_PRE_END_HIGH
                                                 : `AST_PRE_END_LOW));
  assign bit_tick_out = div_tick && pre_end;

  always @* begin
    nxt_div_cnt = div_cnt_ff;
    nxt_pre_cnt = pre_cnt_ff;
    if (!run_in) begin
      // restart from a full count so the first bit is a whole bit
      nxt_div_cnt = div_value_in;
      nxt_pre_cnt = 6'h00;
    end else if (div_tick) begin
      nxt_div_cnt = div_value_in;
      nxt_pre_cnt = pre_end ? 6'h00 : pre_cnt_ff + 6'h01;
    end else begin
      nxt_div_cnt = div_cnt_ff - {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_cnt_ff <= {DIV_W{1'b0}};
      pre_cnt_ff <= 6'h00;
    end else begin
      div_cnt_ff <= nxt_div_cnt;
      pre_cnt_ff <= nxt_pre_cnt;
    end
  end

endmodule

// File: hdl/ast_regs.vh
// register offsets, field positions, reset values and timing counts
// for the asynchronous serial transmitter; included by the hdl files.
`ifndef AST_REGS_VH
`define AST_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// byte offsets on the apb register bus
`define AST_OFF_CTRL 8'h00
`define AST_OFF_HOLD 8'h04
`define AST_OFF_DIV 8'h08
`define AST_OFF_FLAGS 8'h0c
`define AST_OFF_ENABLES 8'h10
`define AST_OFF_PORT 8'h14
`define AST_OFF_STATE 8'h18

////////////////////////////////////////////////////////////////////////////////
// transmit_control_status fields
`define AST_CTRL_NINTH_VAL 0
`define AST_CTRL_SHIFT_EMPTY 1
`define AST_CTRL_HIGH_SPEED 2
`define AST_CTRL_CLOCKED 4
`define AST_CTRL_TX_EN 5
`define AST_CTRL_NINE_SEL 6
// writable bits of the control register
`define AST_CTRL_WMASK 8'h75

// peripheral_flags_one / peripheral_enables_one
`define AST_FLAG_BUF_EMPTY 4
`define AST_ENA_BUF_EMPTY 4

// port control
`define AST_PORT_SERIAL_PORT_ENABLE 7

////////////////////////////////////////////////////////////////////////////////
// reset values
`define AST_RST_CTRL 8'h00
`define AST_RST_DIV 8'h00
`define AST_RST_HOLD 8'h00

////////////////////////////////////////////////////////////////////////////////
// timing: divider ticks per bit, and bits per frame
`define AST_MULT_HIGH 16
`define AST_MULT_LOW 64
`define AST_PRE_END_HIGH 6'h0f
`define AST_PRE_END_LOW 6'h3f
`define AST_FRAME_BITS_8 4'ha
`define AST_FRAME_BITS_9 4'hb

`endif

// File: hdl/ast_tx.v
// asynchronous serial transmitter with apb registers, holding buffer,
// internal shift register and baud divider.
// assumes one 100 MHz clock; all inputs synchronous to it.
`timescale 1ns/1ps
`include "ast_regs.vh"

module ast_tx #(
  parameter DIV_W = 8
) (
  input wire ref_clk_in, // 100 MHz system clock
  input wire rstn_in, // async reset, active low
  input wire psel_in, // apb select
  input wire penable_in, // apb access phase
  input wire pwrite_in, // apb direction, 1 = write
  input wire [7:0] paddr_in, // apb byte address
  input wire [31:0] pwdata_in, // apb write data
  output wire pready_out, // apb ready, always high
  output wire pslverr_out, // apb error on unmapped address
  output wire [31:0] prdata_out, // apb read data
  input wire sleep_in, // processor asleep, freezes transmit progress
  output wire transmit_pin_out, // serial line level
  output wire transmit_pin_oe_out, // high while line driven
  output wire buffer_empty_flag_out // holding buffer empty flag level
);

  ////////////////////////////////////////////////////////////////////////////////
  // apb decode

  // one address compare, shared by the map check and every write strobe
  function reg_hit;
    input [7:0] a;
    input [7:0] off;
    begin
      reg_hit = (a == off);
    end
  endfunction

  function addr_mapped;
    input [7:0] a;
    begin
      addr_mapped = reg_hit(a, `AST_OFF_CTRL) || reg_hit(a, `AST_OFF_HOLD) ||
                    reg_hit(a, `AST_OFF_DIV) || reg_hit(a, `AST_OFF_FLAGS) ||
                    reg_hit(a, `AST_OFF_ENABLES) || reg_hit(a, `AST_OFF_PORT) ||
                    reg_hit(a, `AST_OFF_STATE);
    end
  endfunction

  wire setup_ph;
  wire access_ph;
  wire wr_acc;
  wire wr_ctrl;
  wire wr_hold;
  wire wr_div;
  wire wr_enables;
  wire wr_port;

  assign setup_ph = psel_in && !penable_in;
  assign access_ph = psel_in && penable_in;
  // every register answers at once, so no wait states are ever inserted
  assign pready_out = 1'b1;
  // unmapped addresses answer with an error instead of a silent zero
  assign pslverr_out = access_ph && !addr_mapped(paddr_in);
  assign wr_acc = access_ph && pwrite_in;
  assign wr_ctrl = wr_acc && reg_hit(paddr_in, `AST_OFF_CTRL);
  assign wr_hold = wr_acc && reg_hit(paddr_in, `AST_OFF_HOLD);
  assign wr_div = wr_acc && reg_hit(paddr_in, `AST_OFF_DIV);
  assign wr_enables = wr_acc && reg_hit(paddr_in, `AST_OFF_ENABLES);
  assign wr_port = wr_acc && reg_hit(paddr_in, `AST_OFF_PORT);

  ////////////////////////////////////////////////////////////////////////////////
  // software registers

  reg [7:0] ctrl_ff; // only writable bits stored; status bit merged on read
  reg [DIV_W-1:0] div_value_ff;
  reg buf_int_en_ff;
  reg port_en_ff;
  reg tx_en_d_ff;

  wire nine_sel;
  wire ninth_val;
  wire high_speed;
  wire clocked_mode;
  wire tx_en;
  wire tx_en_rise;
  wire drive_on;
  wire run;

  assign nine_sel = ctrl_ff[`AST_CTRL_NINE_SEL];
  assign ninth_val = ctrl_ff[`AST_CTRL_NINTH_VAL];
  assign high_speed = ctrl_ff[`AST_CTRL_HIGH_SPEED];
  assign clocked_mode = ctrl_ff[`AST_CTRL_CLOCKED];
  assign tx_en = ctrl_ff[`AST_CTRL_TX_EN];
  // delayed copy resets to 0 like the enable, so no false rise after reset
  assign tx_en_rise = tx_en && !tx_en_d_ff;
  // asynchronous transmitter owns the pin only with clocked mode clear
  assign drive_on = port_en_ff && tx_en && !clocked_mode;
  // sleep freezes progress but keeps state and pin level; the divider
  // restarts on wake, so a bit cut by sleep comes out longer than one period
  assign run = drive_on && !sleep_in;

  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_ff <= `AST_RST_CTRL;
      div_value_ff <= `AST_RST_DIV;
      buf_int_en_ff <= 1'b0;
      port_en_ff <= 1'b0;
      tx_en_d_ff <= 1'b0;
    end else begin
      tx_en_d_ff <= tx_en;
      if (wr_ctrl) begin
        ctrl_ff <= pwdata_in[7:0] & `AST_CTRL_WMASK;
      end
      if (wr_div) begin
        div_value_ff <= pwdata_in[DIV_W-1:0];
      end
      if (wr_enables) begin
        buf_int_en_ff <= pwdata_in[`AST_ENA_BUF_EMPTY];
      end
      if (wr_port) begin
        port_en_ff <= pwdata_in[`AST_PORT_SERIAL_PORT_ENABLE];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // baud divider

  wire bit_tick;

  ast_baud #(
    .DIV_W(DIV_W)
  ) u_baud (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .run_in(run),
    .high_speed_in(high_speed),
    .div_value_in(div_value_ff),
    .bit_tick_out(bit_tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // holding buffer and shift register

  reg [7:0] hold_data_ff;
  reg hold_full_ff;
  reg buf_empty_ff;
  reg [9:0] shift_ff; // not on the bus at all
  reg [3:0] bits_left_ff;
  reg [3:0] frame_len_ff;
  reg busy_ff;
  reg line_ff;

  reg [7:0] nxt_hold_data;
  reg nxt_hold_full;
  reg nxt_buf_empty;
  reg [9:0] nxt_shift;
  reg [3:0] nxt_bits_left;
  reg [3:0] nxt_frame_len;
  reg nxt_busy;
  reg nxt_line;
  reg take;

  wire [3:0] frame_len;
  wire [9:0] load_word;

  // stop bit sits above the data; for 8-bit frames the ninth slot is a
  // mark bit sent as the stop bit, and the top bit is never sent because the frame is one shorter
  assign frame_len = nine_sel ? `AST_FRAME_BITS_9 : `AST_FRAME_BITS_8;
  assign load_word = {1'b1, (nine_sel ? ninth_val : 1'b1), hold_data_ff};

  always @* begin
    nxt_shift = shift_ff;
    nxt_bits_left = bits_left_ff;
    nxt_frame_len = frame_len_ff;
    nxt_busy = busy_ff;
    nxt_line = line_ff;
    take = 1'b0;
    if (!drive_on) begin
      // abort: shifter emptied, line back to mark; buffer contents kept
      nxt_busy = 1'b0;
      nxt_bits_left = 4'h0;
      nxt_line = 1'b1;
    end else if (run) begin
      if (!busy_ff) begin
        if (hold_full_ff) begin
          // empty shifter takes the byte at once, no tick needed
          take = 1'b1;
          nxt_shift = load_word;
          nxt_frame_len = frame_len;
          nxt_bits_left = frame_len;
          nxt_busy = 1'b1;
        end
      end else if (bit_tick) begin
        if (bits_left_ff == frame_len_ff) begin
          nxt_line = 1'b0;
          nxt_bits_left = bits_left_ff - 4'h1;
        end else if (bits_left_ff != 4'h0) begin
          nxt_line = shift_ff[0];
          nxt_shift = {1'b1, shift_ff[9:1]};
          nxt_bits_left = bits_left_ff - 4'h1;
        end else if (hold_full_ff) begin
          // stop bit finished: reload and start next frame at once
          take = 1'b1;
          nxt_shift = load_word;
          nxt_frame_len = frame_len;
          nxt_bits_left = frame_len - 4'h1;
          nxt_line = 1'b0;
        end else begin
          nxt_busy = 1'b0;
          nxt_line = 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // holding buffer and buffer-empty flag

  always @* begin
    nxt_hold_data = hold_data_ff;
    nxt_hold_full = hold_full_ff;
    nxt_buf_empty = buf_empty_ff;
    if (take) begin
      nxt_hold_full = 1'b0;
      nxt_buf_empty = 1'b1;
    end
    if (tx_en_rise) begin
      nxt_buf_empty = 1'b1;
    end
    // a write in the transfer cycle leaves fresh data waiting, so the
    // clear beats both sets: the flag must not claim room that is gone
    if (wr_hold) begin
      nxt_hold_data = pwdata_in[7:0];
      nxt_hold_full = 1'b1;
      nxt_buf_empty = 1'b0;
    end
  end

  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hold_data_ff <= `AST_RST_HOLD;
      hold_full_ff <= 1'b0;
      buf_empty_ff <= 1'b0;
      shift_ff <= 10'h3ff;
      bits_left_ff <= 4'h0;
      frame_len_ff <= `AST_FRAME_BITS_8;
      busy_ff <= 1'b0;
      line_ff <= 1'b1;
    end else begin
      hold_data_ff <= nxt_hold_data;
      hold_full_ff <= nxt_hold_full;
      buf_empty_ff <= nxt_buf_empty;
      shift_ff <= nxt_shift;
      bits_left_ff <= nxt_bits_left;
      frame_len_ff <= nxt_frame_len;
      busy_ff <= nxt_busy;
      line_ff <= nxt_line;
    end
  end

  assign transmit_pin_out = line_ff;
  assign transmit_pin_oe_out = drive_on;
  assign buffer_empty_flag_out = buf_empty_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // read data, captured in the setup phase
  // so the access cycle needs no wait state

  reg [31:0] prdata_ff;
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h0000_0000;
    case (paddr_in)
      `AST_OFF_CTRL: begin
        rd_mux[7:0] = ctrl_ff;
        rd_mux[`AST_CTRL_SHIFT_EMPTY] = !busy_ff;
      end
      `AST_OFF_HOLD: begin
        rd_mux[7:0] = hold_data_ff;
      end
      `AST_OFF_DIV: begin
        rd_mux[DIV_W-1:0] = div_value_ff;
      end
      `AST_OFF_FLAGS: begin
        rd_mux[`AST_FLAG_BUF_EMPTY] = buf_empty_ff;
      end
      `AST_OFF_ENABLES: begin
        rd_mux[`AST_ENA_BUF_EMPTY] = buf_int_en_ff;
      end
      `AST_OFF_PORT: begin
        rd_mux[`AST_PORT_SERIAL_PORT_ENABLE] = port_en_ff;
      end
      `AST_OFF_STATE: begin
        rd_mux[0] = hold_full_ff;
        rd_mux[1] = busy_ff;
        rd_mux[2] = line_ff;
        rd_mux[11:8] = bits_left_ff;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prdata_ff <= 32'h0000_0000;
    end else if (setup_ph && !pwrite_in) begin
      prdata_ff <= rd_mux;
    end
  end

  assign prdata_out = prdata_ff;

endmodule
